// *** src/pfim_top.sv ***
// Fault and event interrupt manager with power-up reset release gating
//
// Contract
// - Gate off: release reset without power check
// - Gate on: power good required for release
// - Gate on: power-up faults from regulation ok
// - Check enabled regulators only at release point
// - Fault at release: hold, wait 2.0 ms
// - Still faulty after 2.0 ms: abort, switch off
// - Later regulators monitored, faults start protection
// - Faults after release never stop sequencing
// - Latches set by events, write one clears
// - Mask one blocks line, zero drives it
// - Live bits show present condition level
// - Line is OR of unmasked latches
// - Summary bits reflect unmasked second-level latches
// - Clearing second level clears summary automatically
// - Line held while any bank summary bit or the unmasked warning latch is set
// - Early warning leads shutdown by coded time
// - Regulators use bits 0-2, rest unused
// - Bypassed faults still latch and interrupt
`timescale 1ns/1ps
`include "pfim_consts.svh"

module pfim_top #(
   parameter int STALL_CYC = `PFIM_STALL_US * `PFIM_MCLK_MHZ,
   parameter int EW1_CYC   = `PFIM_EW1_US * `PFIM_MCLK_MHZ,
   parameter int EW2_CYC   = `PFIM_EW2_US * `PFIM_MCLK_MHZ,
   parameter int EW3_CYC   = `PFIM_EW3_US * `PFIM_MCLK_MHZ
) (
   // Clock and reset
   input  wire logic                    mclk,
   input  wire logic                    rst,
   // Register port from the serial slave
   input  wire logic [`PFIM_ADDR_W-1:0] reg_addr,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   input  wire logic [7:0]              reg_wdata,
   output logic      [7:0]              reg_rdata,
   // Power-up sequencer handshake
   input  wire logic                    powergood_gate_select,
   input  wire logic                    seq_at_reset_slot,
   input  wire logic [`PFIM_NREG-1:0]   reg_enabled,
   input  wire logic [`PFIM_NREG-1:0]   regulation_ok,
   output logic                         host_reset_out_n,
   output logic                         seq_hold,
   output logic                         seq_abort,
   output logic      [`PFIM_NREG-1:0]   reg_off,
   // Regulator fault monitors
   input  wire logic [`PFIM_NREG-1:0]   high_output_fault,
   input  wire logic [`PFIM_NREG-1:0]   low_output_fault,
   input  wire logic [`PFIM_NREG-1:0]   current_limit_fault,
   input  wire logic [`PFIM_NREG-1:0]   bypass_high,
   input  wire logic [`PFIM_NREG-1:0]   bypass_low,
   input  wire logic [`PFIM_NREG-1:0]   bypass_current_limit_fault,
   output logic      [`PFIM_NREG-1:0]   fault_start,
   // Other event sources and live levels
   input  wire logic [7:0]              grp1_evt,
   input  wire logic [7:0]              grp1_live,
   input  wire logic [7:0]              grp2_evt,
   input  wire logic [7:0]              grp2_live,
   input  wire logic [`PFIM_NREG-1:0]   mode_evt,
   input  wire logic [7:0]              button_evt,
   input  wire logic [7:0]              button_live,
   input  wire logic [`PFIM_NREG-1:0]   enable_pin,
   // Early warning
   input  wire logic [1:0]              early_warning_delay_sel,
   input  wire logic                    shutdown_req,
   output logic                         shutdown_go,
   // Host interrupt line
   output logic                         irq_out_n
);

   // ----------------------------------------
   // Constants and helpers
   // ----------------------------------------
   localparam int NB   = `PFIM_NBANK;
   localparam int CW   = `PFIM_CNT_W;
   localparam int BLK  = `PFIM_BLANK_US * `PFIM_MCLK_MHZ;
   localparam int EW0  = `PFIM_EW0_US * `PFIM_MCLK_MHZ;

   // Address match against a bank base, used for latch clear and mask write decodes
   function automatic logic bank_hit(input logic [`PFIM_ADDR_W-1:0] a,
                                     input logic [`PFIM_ADDR_W-1:0] base,
                                     input int                      b);
      bank_hit = (a == base + `PFIM_ADDR_W'(b));
   endfunction

   // ----------------------------------------
   // Power-up sequencer
   // ----------------------------------------
   pfim_pkg::pfim_pu_state_t state_q;
   pfim_pkg::pfim_pu_state_t state_d;
   logic [CW-1:0]            stall_q;
   logic [CW-1:0]            blank_q;
   logic                     ok_all;
   logic                     gate_chk;
   logic                     mon_on;

   assign ok_all   = &(regulation_ok | ~reg_enabled);
   assign gate_chk = powergood_gate_select &
                     ((state_q == pfim_pkg::PU_WAIT && seq_at_reset_slot) ||
                      state_q == pfim_pkg::PU_STALL);
   assign mon_on   = (state_q == pfim_pkg::PU_RUN) && (blank_q == CW'(BLK));

   // Next state of the reset release sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         pfim_pkg::PU_WAIT: begin
            if (seq_at_reset_slot && !powergood_gate_select) begin
               state_d = pfim_pkg::PU_RUN;
            end else if (seq_at_reset_slot && ok_all) begin
               state_d = pfim_pkg::PU_RUN;
            end else if (seq_at_reset_slot) begin
               state_d = pfim_pkg::PU_STALL;
            end
         end
         pfim_pkg::PU_STALL: begin
            if (ok_all) begin
               state_d = pfim_pkg::PU_RUN;
            end else if (stall_q == CW'(STALL_CYC - 1)) begin
               state_d = pfim_pkg::PU_ABORT;
            end
         end
         // released state is never left on a fault
         pfim_pkg::PU_RUN:   state_d = pfim_pkg::PU_RUN;
         pfim_pkg::PU_ABORT: state_d = pfim_pkg::PU_ABORT;
         default:            state_d = pfim_pkg::PU_WAIT;
      endcase
   end

   // Sequencer state and its timers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= pfim_pkg::PU_WAIT;
         stall_q <= '0;
         blank_q <= '0;
      end else begin
         state_q <= state_d;
         stall_q <= (state_q == pfim_pkg::PU_STALL) ? stall_q + 1'b1 : '0;
         if (state_q == pfim_pkg::PU_RUN && blank_q != CW'(BLK)) begin
            blank_q <= blank_q + 1'b1;
         end
      end
   end

   // Sequencer outputs, registered from the next state
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         host_reset_out_n <= 1'b0;
         seq_hold         <= 1'b0;
         seq_abort        <= 1'b0;
         reg_off          <= '0;
      end else begin
         host_reset_out_n <= (state_d == pfim_pkg::PU_RUN);
         seq_hold         <= (state_d == pfim_pkg::PU_STALL);
         seq_abort        <= (state_d == pfim_pkg::PU_ABORT);
         if (state_q == pfim_pkg::PU_STALL && state_d == pfim_pkg::PU_ABORT) begin
            reg_off <= reg_enabled;
         end
      end
   end

   // ----------------------------------------
   // Fault sources and edge detection
   // ----------------------------------------
   logic [`PFIM_NREG-1:0] hi_src;
   logic [`PFIM_NREG-1:0] lo_src;
   logic [`PFIM_NREG-1:0] il_src;
   logic [`PFIM_NREG-1:0] hi_prev_q;
   logic [`PFIM_NREG-1:0] lo_prev_q;
   logic [`PFIM_NREG-1:0] il_prev_q;
   logic [`PFIM_NREG-1:0] hi_new;
   logic [`PFIM_NREG-1:0] lo_new;
   logic [`PFIM_NREG-1:0] il_new;

   // power-up faults read from regulation ok
   assign hi_src = mon_on   ? (high_output_fault & reg_enabled) :
                   gate_chk ? (reg_enabled & ~regulation_ok & high_output_fault) : '0;
   assign lo_src = mon_on   ? (low_output_fault & reg_enabled) :
                   gate_chk ? (reg_enabled & ~regulation_ok & ~high_output_fault) : '0;
   assign il_src = mon_on ? (current_limit_fault & reg_enabled) : '0;
   assign hi_new = hi_src & ~hi_prev_q;
   assign lo_new = lo_src & ~lo_prev_q;
   assign il_new = il_src & ~il_prev_q;

   // Edge history and protection start pulses
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hi_prev_q   <= '0;
         lo_prev_q   <= '0;
         il_prev_q   <= '0;
         fault_start <= '0;
      end else begin
         hi_prev_q   <= hi_src;
         lo_prev_q   <= lo_src;
         il_prev_q   <= il_src;
         fault_start <= mon_on ? ((hi_new & ~bypass_high) | (lo_new & ~bypass_low) |
                                  (il_new & ~bypass_current_limit_fault)) : '0;
      end
   end

   // ----------------------------------------
   // Early warning
   // ----------------------------------------
   logic [CW-1:0] ew_cnt_q;
   logic          ew_run_q;
   logic          ew_latch_q;
   logic          ew_mask_q;
   logic [CW-1:0] ew_load;
   logic          sum_wr;
   logic          ctrl_wr;

   assign ew_load = (early_warning_delay_sel == 2'b00) ? CW'(EW0) :
                    (early_warning_delay_sel == 2'b01) ? CW'(EW1_CYC) :
                    (early_warning_delay_sel == 2'b10) ? CW'(EW2_CYC) : CW'(EW3_CYC);
   assign sum_wr  = reg_wr && (reg_addr == `PFIM_SUMMARY);
   assign ctrl_wr = reg_wr && (reg_addr == `PFIM_CTRL);

   // Warning latch set first, shutdown follows after the lead time
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ew_cnt_q    <= '0;
         ew_run_q    <= 1'b0;
         ew_latch_q  <= 1'b0;
         ew_mask_q   <= 1'b1;
         shutdown_go <= 1'b0;
      end else begin
         shutdown_go <= ew_run_q && (ew_cnt_q == CW'(1));
         if (shutdown_req && !ew_run_q) begin
            ew_run_q <= 1'b1;
            ew_cnt_q <= ew_load;
         end else if (ew_run_q) begin
            ew_cnt_q <= ew_cnt_q - 1'b1;
            ew_run_q <= (ew_cnt_q != CW'(1));
         end
         ew_latch_q <= (shutdown_req && !ew_run_q) ||
                       (ew_latch_q && !(sum_wr && reg_wdata[`PFIM_SUM_EWARN]));
         if (ctrl_wr) begin
            ew_mask_q <= reg_wdata[0];
         end
      end
   end

   // ----------------------------------------
   // Second-level latch and mask banks
   // ----------------------------------------
   logic [7:0] evt   [NB];
   logic [7:0] live  [NB];
   logic [7:0] valid [NB];
   logic [7:0] latch_q [NB];
   logic [7:0] mask_q  [NB];
   logic [NB-1:0] summ;

   // Event sources per bank
   assign evt[`PFIM_B_GRP1]   = grp1_evt;
   assign evt[`PFIM_B_GRP2]   = grp2_evt;
   assign evt[`PFIM_B_MODE]   = {5'h00, mode_evt};
   assign evt[`PFIM_B_CURRENT_LIMIT_FAULT]   = {5'h00, il_new};
   assign evt[`PFIM_B_LOW]    = {5'h00, lo_new};
   assign evt[`PFIM_B_HIGH]   = {5'h00, hi_new};
   assign evt[`PFIM_B_BUTTON] = button_evt;

   assign live[`PFIM_B_GRP1]   = grp1_live & `PFIM_VALID_GRP1;
   assign live[`PFIM_B_GRP2]   = grp2_live;
   assign live[`PFIM_B_MODE]   = `PFIM_ZERO8;
   assign live[`PFIM_B_CURRENT_LIMIT_FAULT]   = {5'h00, current_limit_fault};
   assign live[`PFIM_B_LOW]    = {5'h00, low_output_fault};
   assign live[`PFIM_B_HIGH]   = {5'h00, high_output_fault};
   assign live[`PFIM_B_BUTTON] = button_live;

   // regulator banks use bits 0 to 2
   assign valid[`PFIM_B_GRP1]   = `PFIM_VALID_GRP1;
   assign valid[`PFIM_B_GRP2]   = `PFIM_VALID_FULL;
   assign valid[`PFIM_B_MODE]   = `PFIM_VALID_REG;
   assign valid[`PFIM_B_CURRENT_LIMIT_FAULT]   = `PFIM_VALID_REG;
   assign valid[`PFIM_B_LOW]    = `PFIM_VALID_REG;
   assign valid[`PFIM_B_HIGH]   = `PFIM_VALID_REG;
   assign valid[`PFIM_B_BUTTON] = `PFIM_VALID_FULL;

   generate
      for (genvar b = 0; b < NB; b++) begin : g_bank
         logic [7:0] clr;
         logic       mwr;

         assign clr = (reg_wr && bank_hit(reg_addr, `PFIM_LATCH_BASE, b)) ?
                      reg_wdata : `PFIM_ZERO8;
         assign mwr = reg_wr && bank_hit(reg_addr, `PFIM_MASK_BASE, b);
         assign summ[b] = |(latch_q[b] & ~mask_q[b]);

         // Latch and mask storage of one bank
         always_ff @(posedge mclk or posedge rst) begin
            // latches clear, masks block the line
            if (rst) begin
               latch_q[b] <= `PFIM_ZERO8;
               mask_q[b]  <= `PFIM_MASK_RST;
            end else begin
               // set by event, write one clears
               latch_q[b] <= ((latch_q[b] & ~clr) | evt[b]) & valid[b];
               if (mwr) begin
                  mask_q[b] <= reg_wdata & valid[b];
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Interrupt line
   // ----------------------------------------
   logic [7:0] sys_bits;

   assign sys_bits = {ew_latch_q & ~ew_mask_q, summ};

   // Line driven low while any bank summary bit or the unmasked warning latch stands
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_out_n <= 1'b1;
      end else begin
         irq_out_n <= ~(|sys_bits);
      end
   end

   // ----------------------------------------
   // Register read path
   // ----------------------------------------
   logic [2:0] idx;
   logic       in_latch;
   logic       in_mask;
   logic       in_live;
   logic [7:0] rd_mux;

   assign idx      = reg_addr[2:0];
   assign in_latch = (reg_addr[4:3] == 2'b00) && (idx != 3'h7);
   assign in_mask  = (reg_addr[4:3] == 2'b01) && (idx != 3'h7);
   assign in_live  = (reg_addr[4:3] == 2'b10) && (idx != 3'h7);
   // Unmapped offsets read as zero
   assign rd_mux = in_latch ? latch_q[idx] :
                   in_mask  ? mask_q[idx] :
                   in_live  ? live[idx] :
                   (reg_addr == `PFIM_EN_SENSE) ? {5'h00, enable_pin} :
                   (reg_addr == `PFIM_SUMMARY)  ? {ew_latch_q, summ} :
                   (reg_addr == `PFIM_CTRL)     ? {7'h00, ew_mask_q} : `PFIM_ZERO8;

   // Read data captured on the clock edge that samples the strobe
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata <= `PFIM_ZERO8;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end
   end

endmodule

// *** src/pfim_consts.svh ***
// Offsets, field layouts, reset values and timing constants of the fault interrupt manager
`ifndef PFIM_CONSTS_SVH
`define PFIM_CONSTS_SVH

// ----------------------------------------
// Register port geometry
// ----------------------------------------
`define PFIM_ADDR_W     5
`define PFIM_NBANK      7
`define PFIM_NREG       3

// ----------------------------------------
// Register offsets (bank index added to the base)
// ----------------------------------------
`define PFIM_LATCH_BASE 5'h00
`define PFIM_MASK_BASE  5'h08
`define PFIM_LIVE_BASE  5'h10
`define PFIM_EN_SENSE   5'h17
`define PFIM_SUMMARY    5'h18
`define PFIM_CTRL       5'h19

// ----------------------------------------
// Bank indices, also summary bit positions
// ----------------------------------------
`define PFIM_B_GRP1     0
`define PFIM_B_GRP2     1
`define PFIM_B_MODE     2
`define PFIM_B_CURRENT_LIMIT_FAULT     3
`define PFIM_B_LOW      4
`define PFIM_B_HIGH     5
`define PFIM_B_BUTTON   6
`define PFIM_SUM_EWARN  7

// ----------------------------------------
// Implemented bits per bank and reset values
// ----------------------------------------
`define PFIM_VALID_GRP1 8'hFB
`define PFIM_VALID_FULL 8'hFF
`define PFIM_VALID_REG  8'h07
`define PFIM_MASK_RST   8'hFF
`define PFIM_ZERO8      8'h00

// ----------------------------------------
// Timing, in microseconds at a 40 MHz clock
// ----------------------------------------
`define PFIM_MCLK_MHZ   40
`define PFIM_STALL_US   2000
`define PFIM_BLANK_US   10
`define PFIM_EW0_US     100
`define PFIM_EW1_US     5000
`define PFIM_EW2_US     20000
`define PFIM_EW3_US     50000
`define PFIM_CNT_W      21

`endif

// *** src/pfim_pkg.sv ***
// Types shared by the fault interrupt manager
package pfim_pkg;

   // Power-up reset release sequencer states
   typedef enum logic [1:0] {
      PU_WAIT,
      PU_STALL,
      PU_RUN,
      PU_ABORT
   } pfim_pu_state_t;

   typedef logic [7:0] pfim_byte_t;

endpackage

// *** test/pfim_top_properties.sv ***
// Port-level checks of the fault interrupt manager
`timescale 1ns/1ps

module pfim_top_properties #(
   parameter int STALL_CYC = 80000
) (
   // Clock, reset and stimulus
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       reg_wr,
   input wire logic       powergood_gate_select,
   input wire logic       seq_at_reset_slot,
   input wire logic [2:0] reg_enabled,
   input wire logic [2:0] regulation_ok,
   // Observed outputs
   input wire logic       host_reset_out_n,
   input wire logic       seq_hold,
   input wire logic       seq_abort,
   input wire logic [2:0] reg_off,
   input wire logic [2:0] fault_start,
   input wire logic       shutdown_go,
   input wire logic       irq_out_n
);
   // ----------------------------------------
   // Helper logic and checks
   // ----------------------------------------
   int   hold_cnt_q;
   int   hold_cnt_d;
   logic bad_en;

   // Any enabled regulator out of regulation
   assign bad_en = |(reg_enabled & ~regulation_ok);
   // Single pass per reset, so the stall count never clears
   assign hold_cnt_d = seq_hold ? hold_cnt_q + 1 : hold_cnt_q;

   // Stall length counter
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hold_cnt_q <= 0;
      end else begin
         hold_cnt_q <= hold_cnt_d;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   // Sequencer waiting at the reset slot, nothing decided yet
   sequence s_at_slot;
      !host_reset_out_n && !seq_hold && !seq_abort && seq_at_reset_slot;
   endsequence

   a_gate_off_release: assert property (s_at_slot ##0 !powergood_gate_select |=> host_reset_out_n)
      else $error("reset not released with gating off");
   a_gate_on_hold: assert property (s_at_slot ##0 (powergood_gate_select && bad_en) |=> !host_reset_out_n && seq_hold)
      else $error("reset released with a regulator out of regulation");
   a_clean_release: assert property (s_at_slot ##0 (powergood_gate_select && !bad_en) |=> host_reset_out_n)
      else $error("reset held with all regulators good");
   a_stall_release: assert property (seq_hold && !bad_en |=> host_reset_out_n && !seq_hold)
      else $error("stall not left once regulators good");
   a_stall_bound: assert property (seq_hold |-> hold_cnt_q <= STALL_CYC + 1)
      else $error("stall longer than its window");
   a_abort_late: assert property ($rose(seq_abort) |-> hold_cnt_q >= STALL_CYC - 2 && reg_off == reg_enabled && !seq_hold && !host_reset_out_n)
      else $error("abort early or wrong regulators switched off");
   a_release_sticky: assert property (host_reset_out_n |=> host_reset_out_n)
      else $error("reset reasserted after release");
   a_fault_released: assert property (|fault_start |-> host_reset_out_n)
      else $error("protection started before reset release");
   a_warn_pulse: assert property (shutdown_go |=> !shutdown_go)
      else $error("shutdown pulse longer than one cycle");
   a_irq_rise_cause: assert property ($rose(irq_out_n) |-> $past(reg_wr) || $past(reg_wr, 2))
      else $error("interrupt line released without a write");
   a_reset_idle: assert property ($fell(rst) |-> irq_out_n && !host_reset_out_n && !seq_abort)
      else $error("outputs not idle after reset");
endmodule

bind pfim_top pfim_top_properties #(.STALL_CYC(STALL_CYC)) pfim_top_properties_i (
   .mclk, .rst, .reg_wr, .powergood_gate_select, .seq_at_reset_slot, .reg_enabled,
   .regulation_ok, .host_reset_out_n, .seq_hold, .seq_abort, .reg_off, .fault_start,
   .shutdown_go, .irq_out_n
);

// *** test/pfim_host_model.sv ***
// Host processor model driving the register port
`timescale 1ns/1ps
`include "pfim_consts.svh"

module pfim_host_model (
   // Clock and returned data
   input  wire logic [7:0]              reg_rdata,
   input  wire logic                    mclk,
   // Register requests
   output logic      [`PFIM_ADDR_W-1:0] reg_addr,
   output logic                         reg_wr,
   output logic                         reg_rd,
   output logic      [7:0]              reg_wdata
);
   // Idle port at time zero
   initial begin
      reg_addr = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = '0;
   end

   task automatic wr(input logic [`PFIM_ADDR_W-1:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
      // Released bus shows no stale value
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   // Data is taken a full cycle after the strobe edge
   task automatic rd(input logic [`PFIM_ADDR_W-1:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      @(negedge mclk);
      d = reg_rdata;
   endtask
endmodule

// *** test/pfim_top_test.sv ***
// Self-checking bench for the fault interrupt manager
`timescale 1ns/1ps
`include "pfim_consts.svh"

module pfim_top_test;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   localparam int STALL  = 50;
   localparam int EWC[4] = '{4000, 60, 70, 80};
   localparam int BK[4]  = '{0, 1, 2, 6};
   logic                    mclk = 1'b0, rst = 1'b1, shutdown_req = 1'b0;
   logic                    powergood_gate_select = 1'b0, seq_at_reset_slot = 1'b0;
   logic [2:0]              reg_enabled = '0, regulation_ok = '0, mode_evt = '0;
   logic [2:0]              high_output_fault = '0, low_output_fault = '0;
   logic [2:0]              current_limit_fault = '0, bypass_high = '0, bypass_low = '0;
   logic [2:0]              bypass_current_limit_fault = '0, enable_pin = '0, reg_off, fault_start;
   logic [7:0]              grp1_evt = '0, grp2_evt = '0, button_evt = '0, reg_wdata;
   logic [7:0]              grp1_live = '0, grp2_live = '0, button_live = '0;
   logic [7:0]              reg_rdata, rd_v, m, v, e;
   logic [1:0]              early_warning_delay_sel = '0;
   logic [`PFIM_ADDR_W-1:0] reg_addr;
   logic                    reg_wr, reg_rd, host_reset_out_n, seq_hold, seq_abort;
   logic                    shutdown_go, irq_out_n;
   int                      miscompares = 0, total_checks = 0, i, b;

   // 40 MHz clock
   always #12.5 mclk = ~mclk;

   pfim_top #(.STALL_CYC(STALL), .EW1_CYC(60), .EW2_CYC(70), .EW3_CYC(80)) pfim_top_i (
      .mclk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
      .powergood_gate_select, .seq_at_reset_slot, .reg_enabled, .regulation_ok,
      .host_reset_out_n, .seq_hold, .seq_abort, .reg_off, .high_output_fault,
      .low_output_fault, .current_limit_fault, .bypass_high, .bypass_low, .bypass_current_limit_fault,
      .fault_start, .grp1_evt, .grp1_live, .grp2_evt, .grp2_live, .mode_evt, .button_evt,
      .button_live, .enable_pin, .early_warning_delay_sel, .shutdown_req, .shutdown_go,
      .irq_out_n
   );
   pfim_host_model pfim_host_model_i (
      .reg_rdata, .mclk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata
   );

   // Implemented bits of latch banks 0, 1, 2 and 6, the banks the event test drives
   function automatic logic [7:0] valid_bits(input int bk);
      return bk == 0 ? `PFIM_VALID_GRP1 : (bk == 2 ? `PFIM_VALID_REG : `PFIM_VALID_FULL);
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rdc(input logic [`PFIM_ADDR_W-1:0] a, input logic [7:0] exp);
      pfim_host_model_i.rd(a, rd_v);
      chk(rd_v, exp);
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // A used-up wait bound ends the run
   task automatic tmo(input int n, input int lim);
      if (n >= lim) begin
         miscompares++;
         $display("wrong value at %0t: wait ran out", $time);
         finish_test();
      end
   endtask

   task automatic do_reset;
      rst = 1'b1;
      repeat (12) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
   endtask

   // One-cycle event on the source of a bank, 7 is shutdown request
   task automatic pulse(input int bk, input logic [7:0] val);
      @(negedge mclk);
      case (bk)
         0: grp1_evt = val;
         1: grp2_evt = val;
         2: mode_evt = val[2:0];
         6: button_evt = val;
         default: shutdown_req = val[0];
      endcase
      @(negedge mclk);
      {grp1_evt, grp2_evt, mode_evt, button_evt, shutdown_req} = '0;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(17));
      grp1_live = 8'($urandom);
      grp2_live = 8'($urandom);
      button_live = 8'($urandom);
      enable_pin = 3'($urandom);
      bypass_low = 3'($urandom);
      do_reset();
      rdc(`PFIM_LATCH_BASE, 8'h00);
      rdc(`PFIM_MASK_BASE + 5'h01, `PFIM_MASK_RST);
      pfim_host_model_i.wr(5'h1F, 8'hFF);
      rdc(5'h1F, 8'h00);
      rdc(`PFIM_LIVE_BASE, grp1_live & `PFIM_VALID_GRP1);
      rdc(`PFIM_LIVE_BASE + 5'h01, grp2_live);
      rdc(`PFIM_LIVE_BASE + 5'h06, button_live);
      rdc(`PFIM_EN_SENSE, {5'h00, enable_pin});
      $display("reset and live test done");
      powergood_gate_select = 1'b1;
      reg_enabled = 3'h3;
      regulation_ok = 3'h1;
      seq_at_reset_slot = 1'b1;
      for (i = 0; i < STALL + 20 && seq_abort !== 1'b1; i++) @(negedge mclk);
      tmo(i, STALL + 20);
      chk(8'(reg_off), 8'h03);
      chk(8'(host_reset_out_n), 8'h00);
      powergood_gate_select = 1'b0;
      do_reset();
      for (i = 0; i < 4 && host_reset_out_n !== 1'b1; i++) @(negedge mclk);
      tmo(i, 4);
      chk(8'(host_reset_out_n), 8'h01);
      powergood_gate_select = 1'b1;
      do_reset();
      for (i = 0; i < 4 && seq_hold !== 1'b1; i++) @(negedge mclk);
      tmo(i, 4);
      repeat (10) @(negedge mclk);
      chk({seq_hold, host_reset_out_n}, 8'h02);
      regulation_ok = 3'h3;
      for (i = 0; i < 4 && host_reset_out_n !== 1'b1; i++) @(negedge mclk);
      tmo(i, 4);
      chk({seq_hold, host_reset_out_n}, 8'h01);
      do_reset();
      chk(8'(host_reset_out_n), 8'h01);
      $display("power-up test done");
      reg_enabled = 3'h7;
      repeat (420) @(negedge mclk);
      pfim_host_model_i.wr(`PFIM_MASK_BASE + 5'h05, 8'h00);
      high_output_fault = 3'h4;
      @(negedge mclk);
      chk(8'(fault_start), 8'h04);
      repeat (2) @(negedge mclk);
      chk(8'(irq_out_n), 8'h00);
      rdc(`PFIM_LATCH_BASE + 5'h05, 8'h04);
      rdc(`PFIM_SUMMARY, 8'h20);
      rdc(`PFIM_LIVE_BASE + 5'h05, 8'h04);
      high_output_fault = 3'h0;
      pfim_host_model_i.wr(`PFIM_LATCH_BASE + 5'h05, 8'h04);
      rdc(`PFIM_SUMMARY, 8'h00);
      chk(8'(irq_out_n), 8'h01);
      pfim_host_model_i.wr(`PFIM_MASK_BASE + 5'h03, 8'h00);
      bypass_current_limit_fault = 3'h2;
      current_limit_fault = 3'h2;
      @(negedge mclk);
      chk(8'(fault_start), 8'h00);
      repeat (2) @(negedge mclk);
      chk({seq_hold, irq_out_n}, 8'h00);
      rdc(`PFIM_LATCH_BASE + 5'h03, 8'h02);
      current_limit_fault = 3'h0;
      pfim_host_model_i.wr(`PFIM_LATCH_BASE + 5'h03, 8'h02);
      $display("fault test done");
      for (int k = 0; k < 12; k++) begin
         b = BK[$urandom % 4];
         m = 8'($urandom);
         v = 8'($urandom) | 8'h01;
         e = v & valid_bits(b);
         pfim_host_model_i.wr(`PFIM_MASK_BASE + 5'(b), m);
         pulse(b, v);
         rdc(`PFIM_LATCH_BASE + 5'(b), e);
         chk(8'(irq_out_n), 8'((e & ~m) == 8'h00));
         rdc(`PFIM_SUMMARY, ((e & ~m) != 8'h00) ? 8'h01 << b : 8'h00);
         pfim_host_model_i.wr(`PFIM_LATCH_BASE + 5'(b), 8'hFF);
         rdc(`PFIM_LATCH_BASE + 5'(b), 8'h00);
         chk(8'(irq_out_n), 8'h01);
      end
      pulse(1, 8'h10);
      fork
         pfim_host_model_i.wr(`PFIM_LATCH_BASE + 5'h01, 8'h10);
         pulse(1, 8'h10);
      join
      rdc(`PFIM_LATCH_BASE + 5'h01, 8'h10);
      pfim_host_model_i.wr(`PFIM_LATCH_BASE + 5'h01, 8'h10);
      $display("event test done");
      pfim_host_model_i.wr(`PFIM_CTRL, 8'h00);
      for (int c = 0; c < 4; c++) begin
         early_warning_delay_sel = 2'(c);
         pulse(7, 8'h01);
         for (i = 0; i < EWC[c] + 10 && shutdown_go !== 1'b1; i++) @(negedge mclk);
         tmo(i, EWC[c] + 10);
         chk(8'(i + 4 > EWC[c] && i < EWC[c] + 4), 8'h01);
         rdc(`PFIM_SUMMARY, 8'h80);
         chk(8'(irq_out_n), 8'h00);
         pfim_host_model_i.wr(`PFIM_SUMMARY, 8'h80);
      end
      $display("early warning test done");
      finish_test();
   end
endmodule
